// ### asram_ctrl.sv
// Host sequencer that drives an asynchronous 8K x 8 static RAM through its pins.
// Function
// [RULE1] Keep write strobe high throughout every read cycle.
// [RULE2] Address is valid before or when the chip becomes selected.
// [RULE3] Address pins are always driven while the chip is selected.
// [RULE4] Device drives data only when selected, output enabled, strobe high.
// [RULE5] Access and float delays count from last select and first deselect.
// [RULE6] Device keeps equal data stable across back-to-back reads.
// [RULE7] A write happens only while both selects and the strobe are active.
// [RULE8] Write recovery counts from the first edge that ends the write.
// [RULE9] Selecting at or after strobe fall keeps device outputs floating.
// [RULE10] Data driven during a write follows the written data.
// [RULE11] After a write with output enable low, pins show stored data.
// [RULE12] Never drive opposite data onto pins the device is driving.
// [RULE13] Deselect the chip before supply falls toward retention level.
// [RULE14] After retention, wait one read cycle before the next access.
`timescale 1ns/1ps
`include "asram_params.svh"
module asram_ctrl import asram_pkg::*; #(
   parameter int AW = `ASRAM_ADDR_W,
   parameter int DW = `ASRAM_DATA_W
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          req_valid,
   input  wire asram_op_t     req_op,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   output logic               req_ready,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   output logic               retention_ok,
   output logic [AW-1:0]      mem_addr,
   output logic               chip_select_n,
   output logic               chip_select_hi,
   output logic               mem_we_n,
   output logic               mem_oe_n,
   output logic [DW-1:0]      mem_dq_out,
   output logic               mem_dq_oe,
   input  wire logic [DW-1:0] mem_dq_in
);
   // Cycle counts round up, so no device minimum is ever shortened by the clock grid.
   localparam logic [4:0] READ_CYC  = 5'(`ASRAM_CYC_UP(`ASRAM_ACCESS_PS) + 2);
   localparam logic [4:0] WP_CYC    = 5'(`ASRAM_CYC_UP(`ASRAM_WRITE_PULSE_PS));
   localparam logic [4:0] FLOAT_CYC = 5'(`ASRAM_CYC_UP(`ASRAM_FLOAT_PS));
   localparam logic [4:0] RC_CYC    = 5'(`ASRAM_CYC_UP(`ASRAM_READ_CYCLE_PS));

   typedef enum logic [2:0] {
      ASRAM_IDLE, ASRAM_SETUP, ASRAM_RD, ASRAM_WR, ASRAM_REC, ASRAM_RET, ASRAM_WAKE
   } asram_st_t;

   asram_st_t       st_q;
   asram_op_t       op_q;
   logic [DW-1:0]   s1_q;
   logic [DW-1:0]   s2_q;
   asram_timer_if   tif ();

   asram_timer u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .t     (tif)
   );

   // A request is taken only in a state that can serve it; anything else is ignored, not queued.
   logic accept;
   assign accept = (st_q == ASRAM_IDLE || st_q == ASRAM_RET) && req_valid &&
                   (st_q == ASRAM_RET ? req_op == ASRAM_OP_WAKE : req_op != ASRAM_OP_WAKE);

   // Each phase loads the timer once; the read phase carries two extra cycles for the synchroniser.
   always_comb begin
      tif.load  = 1'b0;
      tif.count = 5'h00;
      unique case (st_q)
         ASRAM_IDLE: begin
            tif.load  = accept && (req_op == ASRAM_OP_READ || req_op == ASRAM_OP_WRITE);
            tif.count = 5'h00;
         end
         ASRAM_SETUP: begin
            tif.load  = 1'b1;
            tif.count = (op_q == ASRAM_OP_READ) ? READ_CYC : WP_CYC; // [RULE5]
         end
         ASRAM_RD, ASRAM_WR: begin
            tif.load  = tif.done;
            tif.count = FLOAT_CYC;
         end
         ASRAM_RET: begin
            tif.load  = accept;
            tif.count = RC_CYC; // [RULE14]
         end
         ASRAM_REC, ASRAM_WAKE: begin
            tif.load  = 1'b0;
            tif.count = 5'h00;
         end
      endcase
   end

   // Sequencer: address goes out a cycle before select so it is settled first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ASRAM_IDLE;
         op_q <= ASRAM_OP_READ;
      end else begin
         unique case (st_q)
            ASRAM_IDLE: if (accept) begin
               op_q <= req_op;
               st_q <= (req_op == ASRAM_OP_SLEEP) ? ASRAM_RET : ASRAM_SETUP; // [RULE13]
            end
            ASRAM_SETUP: st_q <= (op_q == ASRAM_OP_READ) ? ASRAM_RD : ASRAM_WR; // [RULE2]
            ASRAM_RD:    if (tif.done) st_q <= ASRAM_REC;
            ASRAM_WR:    if (tif.done) st_q <= ASRAM_REC;
            ASRAM_REC:   if (tif.done) st_q <= ASRAM_IDLE; // [RULE8]
            ASRAM_RET:   if (accept) st_q <= ASRAM_WAKE;
            ASRAM_WAKE:  if (tif.done) st_q <= ASRAM_IDLE; // [RULE14]
         endcase
      end
   end

   // Pin drive. Select and strobe fall together on writes so the device keeps its outputs off.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_select_n  <= 1'b1;
         chip_select_hi <= 1'b0;
         mem_we_n       <= 1'b1;
         mem_oe_n       <= 1'b1;
         mem_dq_oe      <= 1'b0;
      end else begin
         chip_select_n  <= !(st_q == ASRAM_SETUP || ((st_q == ASRAM_RD || st_q == ASRAM_WR) && !tif.done));
         chip_select_hi <= (st_q == ASRAM_SETUP || ((st_q == ASRAM_RD || st_q == ASRAM_WR) && !tif.done));
         mem_we_n       <= !((st_q == ASRAM_SETUP && op_q == ASRAM_OP_WRITE) ||
                             (st_q == ASRAM_WR && !tif.done)); // [RULE1] [RULE9]
         mem_oe_n       <= !((st_q == ASRAM_SETUP && op_q == ASRAM_OP_READ) ||
                             (st_q == ASRAM_RD && !tif.done)); // [RULE12]
         // Data drive outlasts the strobe by one cycle, which gives the device its data hold.
         mem_dq_oe      <= (st_q == ASRAM_SETUP && op_q == ASRAM_OP_WRITE) || st_q == ASRAM_WR; // [RULE12]
      end
   end

   // Address stays driven at all times, never floating; write data reaches the pins only while mem_dq_oe is high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr   <= '0;
         mem_dq_out <= '0;
      end else if (st_q == ASRAM_IDLE && accept) begin
         mem_addr   <= req_addr; // [RULE3]
         mem_dq_out <= req_wdata;
      end
   end

   // Pin inputs pass two flops; sampling is timed so the second stage holds settled data.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= mem_dq_in;
         s2_q <= s1_q;
      end
   end

   // Read data is captured on the last select cycle, once the synchroniser holds settled data.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (st_q == ASRAM_RD && tif.done) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= s2_q; // [RULE4] [RULE6]
         end
      end
   end

   // After a read or write, ready returns only after float recovery, so the device has released the data pins first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready    <= 1'b0;
         retention_ok <= 1'b0;
      end else begin
         req_ready    <= (st_q == ASRAM_IDLE && !accept) || (st_q == ASRAM_RET && !accept) ||
                         ((st_q == ASRAM_REC || st_q == ASRAM_WAKE) && tif.done);
         retention_ok <= (st_q == ASRAM_RET && !accept) || (st_q == ASRAM_IDLE && accept &&
                         req_op == ASRAM_OP_SLEEP); // [RULE13]
      end
   end

   // Pin checks sample on the controller clock, so edge order inside one cycle is not visible here.
   a_read_we_high: assert property (@(posedge clk) disable iff (!rst_n)
      !mem_oe_n |-> mem_we_n) else $error("Write strobe low during read."); // [RULE1]
   a_addr_before_sel: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(chip_select_n) |-> $stable(mem_addr)) else $error("Address changed at select."); // [RULE2]
   a_addr_held_sel: assert property (@(posedge clk) disable iff (!rst_n)
      !chip_select_n |=> $stable(mem_addr) || chip_select_n) else $error("Address moved while selected."); // [RULE3]
   a_no_contention: assert property (@(posedge clk) disable iff (!rst_n)
      mem_dq_oe |-> mem_oe_n) else $error("Data driven while device outputs on."); // [RULE12]
   a_write_overlap: assert property (@(posedge clk) disable iff (!rst_n)
      !mem_we_n |-> !chip_select_n && chip_select_hi && mem_dq_oe) else $error("Strobe outside select."); // [RULE7]
   a_write_sel_same: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_we_n) |-> $fell(chip_select_n)) else $error("Select before strobe fall."); // [RULE9]
   a_sleep_desel: assert property (@(posedge clk) disable iff (!rst_n)
      retention_ok |-> chip_select_n && !chip_select_hi) else $error("Retention while selected."); // [RULE13]
   a_wake_wait: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ASRAM_RET && accept |=> !req_ready [*8]) else $error("Access too soon after retention."); // [RULE14]
   a_read_len: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_oe_n) |-> !mem_oe_n [*8]) else $error("Read strobe too short."); // [RULE5]
   // Recovery, hold and retention checks; the strobe never outlives either select here.
   a_sel_pair: assert property (@(posedge clk) disable iff (!rst_n)
      chip_select_n == !chip_select_hi) else $error("Selects out of step."); // [RULE2]
   a_rec_gap: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(chip_select_n) |-> chip_select_n [*4]) else $error("Select back before recovery."); // [RULE8]
   a_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(mem_we_n) |-> mem_dq_oe) else $error("Write data dropped with strobe."); // [RULE8]
   a_we_data_on: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_we_n) |-> mem_dq_oe && mem_oe_n) else $error("Strobe without data drive."); // [RULE12]
   a_read_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !mem_oe_n |-> $stable(mem_addr)) else $error("Address moved during read."); // [RULE3]
   a_ret_pins_idle: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ASRAM_RET |-> chip_select_n && mem_we_n) else $error("Pins active in retention."); // [RULE13]
   a_wake_no_sel: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ASRAM_WAKE |-> chip_select_n) else $error("Select during wake wait."); // [RULE14]
   a_ready_desel: assert property (@(posedge clk) disable iff (!rst_n)
      req_ready |-> chip_select_n && mem_we_n) else $error("Ready while chip selected."); // [RULE14]
endmodule

// ### asram_dev_model.sv
// Behavioural model of the 8K x 8 static RAM seen from its pins.
`timescale 1ns/1ps
module asram_dev_model #(
   parameter int ACC_NS = 60
) (
   input  wire logic [12:0] addr,
   input  wire logic        sel_n,
   input  wire logic        sel_hi,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [7:0]  din,
   output logic      [7:0]  dout,
   output logic             drive
);
   logic [7:0] mem [0:8191];
   logic [7:0] last_q;
   logic       wr_act;
   assign wr_act = !sel_n && sel_hi && !we_n;
   // Data is taken when the first release ends the write, so late data still lands.
   always @(negedge wr_act) mem[addr] = din;
   assign drive = !sel_n && sel_hi && !oe_n && we_n;
   always @* if (drive) last_q = mem[addr];
   // A released bus shows the inverse of its last value, so a stale sample cannot pass.
   assign #(ACC_NS) dout = drive ? last_q : ~last_q;
endmodule

// ### asram_params.svh
// Timing and geometry constants for the asynchronous SRAM host controller.
`ifndef ASRAM_PARAMS_SVH
`define ASRAM_PARAMS_SVH
`define ASRAM_CLK_PERIOD_PS   8000
`define ASRAM_ADDR_W          13
`define ASRAM_DATA_W          8
`define ASRAM_READ_CYCLE_PS   70000
`define ASRAM_ACCESS_PS       70000
`define ASRAM_WRITE_PULSE_PS  35000
`define ASRAM_FLOAT_PS        30000
`define ASRAM_RETENTION_SETUP_PS 0
`define ASRAM_CYC_UP(ps)      (((ps) + `ASRAM_CLK_PERIOD_PS - 1) / `ASRAM_CLK_PERIOD_PS)
`define ASRAM_CNT_W           5
`endif

// ### asram_pkg.sv
// Types shared by the asynchronous SRAM host controller.
package asram_pkg;
   typedef enum logic [1:0] {
      ASRAM_OP_READ,
      ASRAM_OP_WRITE,
      ASRAM_OP_SLEEP,
      ASRAM_OP_WAKE
   } asram_op_t;
endpackage

// ### asram_timer.sv
// Down counter that times each phase of a memory cycle.
`timescale 1ns/1ps
module asram_timer (
   input wire logic clk,
   input wire logic rst_n,
   asram_timer_if.tmr t
);
   logic [4:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 5'h00;
      end else if (t.load) begin
         cnt_q <= t.count;
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   // Done looks only at the count, so a sequencer that reloads on done forms no combinational loop.
   assign t.done = (cnt_q == 5'h00);
endmodule

// ### asram_timer_if.sv
// Handshake between the sequencer and its cycle timer.
`timescale 1ns/1ps
interface asram_timer_if;
   logic       load;
   logic [4:0] count;
   logic       done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// ### tb_asram_ctrl.sv
// Self-checking bench for the asynchronous SRAM host controller.
`timescale 1ns/1ps
module tb_asram_ctrl import asram_pkg::*;;
   logic        clk, rst_n, req_valid, req_ready, rsp_valid, retention_ok;
   logic        sel_n, sel_hi, we_n, oe_n, dq_oe, dev_drive;
   asram_op_t   req_op;
   logic [12:0] req_addr, mem_addr;
   logic [7:0]  req_wdata, rsp_rdata, dq_out, dev_dout;
   int          n_fail, samples_checked;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   asram_ctrl u_asram_ctrl (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .retention_ok(retention_ok), .mem_addr(mem_addr), .chip_select_n(sel_n), .chip_select_hi(sel_hi),
      .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe),
      .mem_dq_in(dq_oe ? dq_out : dev_dout));
   asram_dev_model u_asram_dev_model (.addr(mem_addr), .sel_n(sel_n), .sel_hi(sel_hi), .we_n(we_n), .oe_n(oe_n),
      .din(dq_out), .dout(dev_dout), .drive(dev_drive));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t %s: %h vs %h", $time, what, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic req(input asram_op_t op, input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 64) begin
         tick(1);
         n++;
      end
      chk({7'h00, req_ready}, 8'h01, "ready wait");
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      tick(1);
      req_valid = 1'b0;
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      req(ASRAM_OP_READ, a, 8'h00);
      while (rsp_valid !== 1'b1 && n < 40) begin
         chk({7'h00, we_n}, 8'h01, "strobe in read");
         tick(1);
         n++;
      end
      chk({7'h00, rsp_valid}, 8'h01, "read answer");
      chk(rsp_rdata, exp, "read data");
   endtask
   always @(negedge clk) begin
      if (rst_n) begin
         chk({7'h00, dq_oe & dev_drive}, 8'h00, "bus contention");
      end
   end
   task automatic t_rw;
      req(ASRAM_OP_WRITE, 13'h0000, 8'h5a);
      req(ASRAM_OP_WRITE, 13'h1fff, 8'ha5);
      req(ASRAM_OP_WRITE, 13'h0000, 8'hc3);
      rd(13'h1fff, 8'ha5);
      rd(13'h1fff, 8'ha5);
      rd(13'h0000, 8'hc3);
      $display("test read_write done");
   endtask
   task automatic t_sleep;
      int n;
      req(ASRAM_OP_SLEEP, 13'h0000, 8'h00);
      n = 0;
      while (retention_ok !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk({6'h00, sel_n, sel_hi}, 8'h02, "deselected");
      tick(1);
      req_valid = 1'b1;
      req_op = ASRAM_OP_READ;
      tick(1);
      req_valid = 1'b0;
      tick(3);
      chk({7'h00, retention_ok}, 8'h01, "read ignored");
      req(ASRAM_OP_WAKE, 13'h0000, 8'h00);
      for (n = 0; n < 9; n++) begin
         chk({5'h00, sel_n, req_ready, retention_ok}, 8'h04, "wake wait");
         tick(1);
      end
      rd(13'h0000, 8'hc3);
      $display("test retention done");
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      tick(5000);
      n_fail++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = ASRAM_OP_READ;
      req_addr = 13'h0000;
      req_wdata = 8'h00;
      n_fail = 0;
      samples_checked = 0;
      tick(8);
      chk({6'h00, sel_n, sel_hi}, 8'h02, "reset selects");
      rst_n = 1'b1;
      t_rw();
      t_sleep();
      test_done();
   end
endmodule
